// >>> rtl/dispoc_pkg.sv
// Package: register map, field positions and codes for display output config
package dispoc_pkg;

    localparam logic [11:0] FMT_CTRL_OFS  = 12'h000;
    localparam logic [11:0] PIN_CTRL_OFS  = 12'h004;
    localparam logic [11:0] PAD_STAT_OFS  = 12'h008;

    localparam logic [15:0] FMT_CTRL_RST  = 16'h0000;
    localparam logic [15:0] PIN_CTRL_RST  = 16'h0000;

    localparam int GLASS_LSB = 0;
    localparam int DEPTH_LSB = 5;
    localparam int TEST_LSB  = 8;

    localparam int HSOE_BIT  = 0;
    localparam int VSOE_BIT  = 1;
    localparam int ENOE_BIT  = 2;
    localparam int PWROE_BIT = 3;
    localparam int HSPOL_BIT = 4;
    localparam int VSPOL_BIT = 5;
    localparam int ENPOL_BIT = 6;
    localparam int CKPOL_BIT = 7;
    localparam int PWR_BIT   = 8;
    localparam int PINOE_BIT = 9;

    localparam logic [15:0] FMT_CTRL_MASK = 16'h03E7;
    localparam logic [15:0] PIN_CTRL_MASK = 16'h03FF;

    typedef enum logic [1:0] {
        DISPOC_PAT_NONE    = 2'h0,
        DISPOC_PAT_BLACK   = 2'h1,
        DISPOC_PAT_BARS    = 2'h2,
        DISPOC_PAT_BORDERS = 2'h3
    } dispoc_pattern_type;

    typedef enum logic [2:0] {
        DISPOC_BPP_1  = 3'h0,
        DISPOC_BPP_2  = 3'h1,
        DISPOC_BPP_4  = 3'h2,
        DISPOC_BPP_8  = 3'h3,
        DISPOC_BPP_16 = 3'h4
    } dispoc_depth_type;

    typedef enum logic [2:0] {
        DISPOC_GLASS_OFF   = 3'h0,
        DISPOC_GLASS_TFT   = 3'h1,
        DISPOC_GLASS_MONO  = 3'h2,
        DISPOC_GLASS_COLOR = 3'h3
    } dispoc_glass_type;

    // Log2 of the bar width in pixels for the pattern generator
    localparam logic [3:0] BAR_SHIFT = 4'h5;

    // Raw timing/pixel stream from the display engine
    typedef struct packed {
        logic [15:0] data;
        logic        den;
        logic        vsync;
        logic        hsync;
        logic        first_col;
        logic        last_col;
        logic        first_row;
        logic        last_row;
        logic [10:0] col;
    } dispoc_video_type;

    // Pad-level outputs: value and active-low output enable
    typedef struct packed {
        logic [15:0] data;
        logic [15:0] data_oe_n;
        logic        den;
        logic        den_oe_n;
        logic        vsync;
        logic        vsync_oe_n;
        logic        hsync;
        logic        hsync_oe_n;
        logic        pwr;
        logic        pwr_oe_n;
    } dispoc_pads_type;

endpackage

// >>> rtl/dispoc_pattern.sv
// Test pattern generator that replaces pixel data on the display stream
module dispoc_pattern (
    input  wire logic                        clk,
    input  wire logic                        nrst,
    input  wire dispoc_pkg::dispoc_pattern_type mode,
    input  wire dispoc_pkg::dispoc_depth_type   depth,
    input  wire dispoc_pkg::dispoc_video_type   vin,
    output logic [15:0]                      data_r
);
    logic [15:0] full;
    logic [15:0] pix_nxt;
    logic [2:0]  bar_idx;
    logic        edge_px;

    always_comb begin
        case (depth)
            dispoc_pkg::DISPOC_BPP_1:  full = 16'h0001;
            dispoc_pkg::DISPOC_BPP_2:  full = 16'h0003;
            dispoc_pkg::DISPOC_BPP_4:  full = 16'h000F;
            dispoc_pkg::DISPOC_BPP_8:  full = 16'h00FF;
            default:                   full = 16'hFFFF;
        endcase
    end

    assign bar_idx = 3'(vin.col >> dispoc_pkg::BAR_SHIFT);
    assign edge_px = vin.first_col | vin.last_col |
                     vin.first_row | vin.last_row;

    // R1 pattern selection
    always_comb begin
        case (mode)
            dispoc_pkg::DISPOC_PAT_BORDERS: pix_nxt = edge_px ? full : 16'h0000;
            dispoc_pkg::DISPOC_PAT_BARS:
                pix_nxt = full & {bar_idx, bar_idx, bar_idx, bar_idx,
                                  bar_idx, bar_idx[0]};
            dispoc_pkg::DISPOC_PAT_BLACK:   pix_nxt = 16'h0000;
            default:                        pix_nxt = vin.data;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            data_r <= 16'h0000;
        end else begin
            data_r <= pix_nxt;
        end
    end
endmodule

// >>> rtl/dispoc_top.sv
// Display output configuration: APB registers, pattern and pad gating
// Summary of operation
// R1: Two-bit field picks test pattern or image
// R2: Three-bit colour depth code, software matches
// R3: Three-bit field selects glass type
// R4: Master pad enable gates data, enable, syncs
// R5: Power output follows sequencer bit when enabled
// R6: Vsync driven only when port enabled
// R7: Enable polarity bit selects active level
module dispoc_top (
    input  wire logic                      clk,
    input  wire logic                      nrst,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [11:0]               paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire dispoc_pkg::dispoc_video_type vin,
    output dispoc_pkg::dispoc_pads_type    pads,
    output logic                           glass_clock_polarity,
    output dispoc_pkg::dispoc_glass_type   glass_type_select,
    output dispoc_pkg::dispoc_depth_type   display_color_depth
);
    logic [15:0] display_format_control_r;
    logic [15:0] display_pin_control_r;
    logic [15:0] pat_data;
    logic        den_d_r;
    logic        vs_d_r;
    logic        hs_d_r;
    logic        wr_en;
    logic        rd_en;
    logic        hit;
    logic [31:0] rdata_nxt;
    logic        glass_on;
    logic        en_pol;
    logic        pin_oe;
    dispoc_pkg::dispoc_pattern_type test_pattern_select;
    dispoc_pkg::dispoc_pads_type    pads_nxt;

    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & ~penable & ~pwrite;
    assign hit = (paddr == dispoc_pkg::FMT_CTRL_OFS) ||
                 (paddr == dispoc_pkg::PIN_CTRL_OFS) ||
                 (paddr == dispoc_pkg::PAD_STAT_OFS);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~hit;

    // R1 pattern field decode
    assign test_pattern_select = dispoc_pkg::dispoc_pattern_type'(
        display_format_control_r[dispoc_pkg::TEST_LSB +: 2]);
    // R2 colour depth field
    assign display_color_depth = dispoc_pkg::dispoc_depth_type'(
        display_format_control_r[dispoc_pkg::DEPTH_LSB +: 3]);
    // R3 glass type field
    assign glass_type_select = dispoc_pkg::dispoc_glass_type'(
        display_format_control_r[dispoc_pkg::GLASS_LSB +: 3]);
    assign glass_clock_polarity =
        display_pin_control_r[dispoc_pkg::CKPOL_BIT];

    // Reserved glass codes leave the pads idle like code 000
    assign glass_on = (glass_type_select == dispoc_pkg::DISPOC_GLASS_TFT) ||
                      (glass_type_select == dispoc_pkg::DISPOC_GLASS_MONO) ||
                      (glass_type_select == dispoc_pkg::DISPOC_GLASS_COLOR);

    always_ff @(posedge clk) begin
        if (!nrst) begin
            display_format_control_r <= dispoc_pkg::FMT_CTRL_RST;
        end else if (wr_en && paddr == dispoc_pkg::FMT_CTRL_OFS) begin
            display_format_control_r <=
                pwdata[15:0] & dispoc_pkg::FMT_CTRL_MASK;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            display_pin_control_r <= dispoc_pkg::PIN_CTRL_RST;
        end else if (wr_en && paddr == dispoc_pkg::PIN_CTRL_OFS) begin
            display_pin_control_r <=
                pwdata[15:0] & dispoc_pkg::PIN_CTRL_MASK;
        end
    end

    always_comb begin
        if (paddr == dispoc_pkg::FMT_CTRL_OFS) begin
            rdata_nxt = {16'h0000, display_format_control_r};
        end else if (paddr == dispoc_pkg::PIN_CTRL_OFS) begin
            rdata_nxt = {16'h0000, display_pin_control_r};
        end else if (paddr == dispoc_pkg::PAD_STAT_OFS) begin
            rdata_nxt = {27'h0000000, pads.pwr, pads.hsync_oe_n,
                         pads.vsync_oe_n, pads.den_oe_n, pads.data_oe_n[0]};
        end else begin
            rdata_nxt = 32'h00000000;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            prdata <= 32'h00000000;
        end else if (rd_en) begin
            prdata <= rdata_nxt;
        end
    end

    dispoc_pattern u_pattern (
        .clk    (clk),
        .nrst   (nrst),
        .mode   (test_pattern_select),
        .depth  (display_color_depth),
        .vin    (vin),
        .data_r (pat_data)
    );

    // Delay timing signals to align with pattern data
    always_ff @(posedge clk) begin
        if (!nrst) begin
            den_d_r <= 1'b0;
            vs_d_r  <= 1'b0;
            hs_d_r  <= 1'b0;
        end else begin
            den_d_r <= vin.den;
            vs_d_r  <= vin.vsync;
            hs_d_r  <= vin.hsync;
        end
    end

    assign en_pol = display_pin_control_r[dispoc_pkg::ENPOL_BIT];
    assign pin_oe = display_pin_control_r[dispoc_pkg::PINOE_BIT] & glass_on;

    always_comb begin
        pads_nxt = '0;
        pads_nxt.data = pat_data;
        // R7 enable polarity
        pads_nxt.den = en_pol ? den_d_r : ~den_d_r;
        pads_nxt.vsync =
            display_pin_control_r[dispoc_pkg::VSPOL_BIT] ? vs_d_r : ~vs_d_r;
        pads_nxt.hsync =
            display_pin_control_r[dispoc_pkg::HSPOL_BIT] ? hs_d_r : ~hs_d_r;
        // R4 master pad enable gating
        pads_nxt.data_oe_n = {16{~pin_oe}};
        pads_nxt.den_oe_n =
            ~(pin_oe & display_pin_control_r[dispoc_pkg::ENOE_BIT]);
        // R6 vsync port enable
        pads_nxt.vsync_oe_n =
            ~(pin_oe & display_pin_control_r[dispoc_pkg::VSOE_BIT]);
        pads_nxt.hsync_oe_n =
            ~(pin_oe & display_pin_control_r[dispoc_pkg::HSOE_BIT]);
        // R5 power sequencer output
        pads_nxt.pwr = display_pin_control_r[dispoc_pkg::PWR_BIT];
        pads_nxt.pwr_oe_n = ~display_pin_control_r[dispoc_pkg::PWROE_BIT];
        // Disabled vsync and enable pins hold their inactive level
        if (pads_nxt.vsync_oe_n) begin
            pads_nxt.vsync = ~display_pin_control_r[dispoc_pkg::VSPOL_BIT];
        end
        if (pads_nxt.den_oe_n) begin
            pads_nxt.den = ~en_pol;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            pads <= '{default: 1'b0, data_oe_n: 16'hFFFF, den_oe_n: 1'b1,
                      vsync_oe_n: 1'b1, hsync_oe_n: 1'b1, pwr_oe_n: 1'b1};
        end else begin
            pads <= pads_nxt;
        end
    end
endmodule

// >>> verif/dispoc_sva.sv
// Checker: port assertions for the display output config block
module dispoc_sva (
    input wire logic                         clk,
    input wire logic                         nrst,
    input wire logic                         psel,
    input wire logic                         penable,
    input wire logic                         pwrite,
    input wire logic [11:0]                  paddr,
    input wire logic [31:0]                  pwdata,
    input wire logic                         pready,
    input wire dispoc_pkg::dispoc_video_type vin,
    input wire dispoc_pkg::dispoc_pads_type  pads,
    input wire dispoc_pkg::dispoc_glass_type glass_type_select,
    input wire dispoc_pkg::dispoc_depth_type display_color_depth
);
    logic [15:0] fmt_r;
    logic [15:0] pin_r;
    logic        q_r;
    logic        q1_r;
    logic        wr;
    logic        on;
    assign wr = psel & penable & pwrite & pready;
    assign on = pin_r[9] && fmt_r[2:0] inside {3'h1, 3'h2, 3'h3};
    // Shadow copies of the two config registers
    always_ff @(posedge clk) begin
        if (!nrst) begin
            fmt_r <= 16'h0000;
            pin_r <= 16'h0000;
        end else if (wr && paddr == dispoc_pkg::FMT_CTRL_OFS) begin
            fmt_r <= pwdata[15:0];
        end else if (wr && paddr == dispoc_pkg::PIN_CTRL_OFS) begin
            pin_r <= pwdata[15:0];
        end
    end
    // Pads lag registers by up to two edges: skip two edges after a change
    always_ff @(posedge clk) begin
        q1_r <= nrst && !(wr && paddr < 12'h008);
        q_r  <= q1_r && nrst && !(wr && paddr < 12'h008);
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!nrst);
    sequence s_fmt_wr;
        wr && paddr == dispoc_pkg::FMT_CTRL_OFS;
    endsequence
    property p_glass;
        s_fmt_wr |=> glass_type_select == $past(pwdata[2:0]);
    endproperty
    property p_depth;
        s_fmt_wr |=> display_color_depth == $past(pwdata[7:5]);
    endproperty
    property p_black;
        q_r && fmt_r[9:8] == 2'h1 |-> pads.data == 16'h0000;
    endproperty
    property p_plain;
        q_r && fmt_r[9:5] == 5'h04 |-> pads.data == $past(vin.data, 2);
    endproperty
    property p_master;
        q_r && !pin_r[9] |-> pads.data_oe_n == 16'hFFFF && pads.den_oe_n
            && pads.vsync_oe_n && pads.hsync_oe_n;
    endproperty
    property p_vs_on;
        q_r && on && pin_r[1] |-> !pads.vsync_oe_n;
    endproperty
    property p_vs_off;
        q_r && !pin_r[1] |-> pads.vsync_oe_n && pads.vsync == !pin_r[5];
    endproperty
    property p_enpol;
        q_r && on && pin_r[2] |->
            pads.den == (pin_r[6] ~^ $past(vin.den, 2));
    endproperty
    property p_pwr;
        q_r && pin_r[3] |-> !pads.pwr_oe_n && pads.pwr == pin_r[8];
    endproperty
    a_glass: assert property (p_glass) else $error("glass type");
    a_depth: assert property (p_depth) else $error("depth");
    a_black: assert property (p_black) else $error("black");
    a_plain: assert property (p_plain) else $error("image");
    a_master: assert property (p_master) else $error("master");
    a_vs_on: assert property (p_vs_on) else $error("vsync on");
    a_vs_off: assert property (p_vs_off) else $error("vsync off");
    a_enpol: assert property (p_enpol) else $error("den level");
    a_pwr: assert property (p_pwr) else $error("power");
endmodule

bind dispoc_top dispoc_sva u_sva (
    .clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
    .vin, .pads, .glass_type_select, .display_color_depth
);

// >>> verif/dispoc_panel.sv
// Panel model: the line levels the glass sees at the display pads
module dispoc_panel (
    input  wire logic                        clk,
    input  wire dispoc_pkg::dispoc_pads_type pads,
    output logic [19:0]                      seen
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [19:0] last_r = 20'h00000;
    logic [19:0] drv;
    logic [19:0] off;
    assign drv = {pads.data, pads.den, pads.vsync, pads.hsync, pads.pwr};
    assign off = {pads.data_oe_n, pads.den_oe_n, pads.vsync_oe_n,
                  pads.hsync_oe_n, pads.pwr_oe_n};
    // Released lines float to the inverse of the level last driven
    assign seen = (drv & ~off) | (~last_r & off);
    always @(posedge clk) begin
        last_r <= (drv & ~off) | (last_r & off);
    end
endmodule

// >>> verif/display_output_config_tb_top.sv
// Testbench: APB register and pad checks for display output config
module display_output_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic                         clk, nrst, psel, penable, pwrite;
    logic [11:0]                  paddr;
    logic [31:0]                  pwdata, prdata, rdat;
    logic                         pready, pslverr, serr, gpol;
    dispoc_pkg::dispoc_video_type vin;
    dispoc_pkg::dispoc_pads_type  pads;
    dispoc_pkg::dispoc_glass_type glass;
    dispoc_pkg::dispoc_depth_type depth;
    logic [19:0]                  seen;
    logic [15:0]                  pexp [4] = '{16'hA5C3, 16'h0, 16'h0, 16'hFFFF};
    int                           num_errors, compares;
    dispoc_top uut (.clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .vin, .pads, .glass_clock_polarity(gpol),
        .glass_type_select(glass), .display_color_depth(depth));
    dispoc_panel panel (.clk, .pads, .seen);
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rdat = prdata;
        serr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic settle(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
        repeat (3) @(posedge clk);
    endtask
    task automatic wrap_up;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end
    initial begin
        #100us;
        num_errors++;
        wrap_up();
    end
    initial begin
        {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
        vin = '0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, dispoc_pkg::FMT_CTRL_OFS, 32'h0);
        chk(rdat, {16'h0, dispoc_pkg::FMT_CTRL_RST});
        apb(1'b0, dispoc_pkg::PIN_CTRL_OFS, 32'h0);
        chk(rdat, {16'h0, dispoc_pkg::PIN_CTRL_RST});
        chk({pads.den_oe_n, pads.data_oe_n}, 17'h1FFFF);
        apb(1'b1, 12'h00C, 32'hFFFF);
        chk(serr, 1'b1);
        apb(1'b0, 12'h00C, 32'h0);
        chk(serr, 1'b1);
        chk(rdat, 32'h00000000);
        $display("test reset and map done");
        for (int g = 1; g < 4; g++) begin
            for (int d = 0; d < 5; d++) begin
                settle(12'h000, {24'h0, d[2:0], 2'h0, g[2:0]});
                chk({glass, depth}, {g[2:0], d[2:0]});
            end
        end
        $display("test glass and depth done");
        vin <= '{data: 16'hA5C3, den: 1'b1, vsync: 1'b1, first_col: 1'b1,
                 default: '0};
        for (int p = 0; p < 4; p++) begin
            settle(12'h000, {22'h0, p[1:0], 8'h81});
            chk(pads.data, pexp[p]);
        end
        $display("test patterns done");
        settle(12'h000, 32'h0081);
        settle(12'h004, 32'h0347);
        chk(seen, {16'hA5C3, 4'hB});
        chk(pads.pwr_oe_n, 1'b1);
        settle(12'h004, 32'h010D);
        chk({pads.data_oe_n[0], pads.den_oe_n, pads.vsync_oe_n}, 3'h7);
        chk({pads.pwr_oe_n, seen[0]}, 2'b01);
        settle(12'h004, 32'h0204);
        chk({pads.den_oe_n, pads.den, pads.vsync_oe_n, pads.vsync}, 4'h3);
        apb(1'b0, dispoc_pkg::PAD_STAT_OFS, 32'h0);
        chk(rdat, 32'h0000000C);
        settle(12'h000, 32'h0080);
        chk(pads.den_oe_n, 1'b1);
        settle(12'h004, 32'hFFFFFFFF);
        chk(gpol, 1'b1);
        apb(1'b0, dispoc_pkg::PIN_CTRL_OFS, 32'h0);
        chk(rdat, {16'h0, dispoc_pkg::PIN_CTRL_MASK});
        $display("test pads done");
        @(posedge clk);
        nrst <= 1'b0;
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        apb(1'b0, dispoc_pkg::PIN_CTRL_OFS, 32'h0);
        chk(rdat, {16'h0, dispoc_pkg::PIN_CTRL_RST});
        chk({gpol, pads.pwr_oe_n, pads.den_oe_n}, 3'h3);
        $display("test mid-run reset done");
        wrap_up();
    end
endmodule
